// file: rtl/rx_config_calibration_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Divide crystal to 100kHz by divisor register
// - Reference times calibration and wake sequence
// - Commands: nop, write, read, master reset
// - Low gain for dwell, then LNA high
// - Dwell is two to register crystal periods
// - Dwell register resets to 0x0D
// - Poll calibration start self-clears, sets done
// - FSK calibration honours accuracy, self-clears, done
// - Wake cycle recalibrates poll timer, and FSK when FSK baseband is enabled
// - Eleven registers at addresses 0x0 to 0xA
// - Sixteen-bit sleep interval sets low-power time
// - Host wake delay extends low-power time
// - Settle: modules on, peaks and outputs held
// - Host must pull line low or restart
// - Status reports lock, gain, clock, done flags
// - Frame: command, address, data, MSB first
// - Master reset held while select stays high
module rx_config_calibration_regs (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic SCLK,
    input wire logic CHIP_SEL_N,
    input wire logic BIDIR_SERIAL_LINE_IN,
    output logic BIDIR_SERIAL_LINE_OUT,
    output logic BIDIR_SERIAL_LINE_OE_N,
    input wire logic XTAL_CLK,
    input wire logic POWER_BELOW_THRESH,
    input wire logic PLL_LOCKED,
    output logic [7:0] POWER_CONFIG,
    output logic [7:0] DEVICE_CONFIG,
    output logic [7:0] XTAL_DIVISOR,
    output logic REF_TICK,
    output logic LNA_HIGH_GAIN,
    output logic RX_MODULES_ON,
    output logic PEAK_DET_HOLD,
    output logic DATA_OUT_EN,
    output logic ASK_TRACK_EN,
    output logic FSK_TRACK_EN
);

    typedef enum {DRX_IDLE, DRX_OFF, DRX_CPU, DRX_RF, DRX_RECV} drx_state_t;

    typedef struct packed {
        logic sclk_m, sclk_s, sclk_p;
        logic cs_m, cs_s, cs_p;
        logic dio_m, dio_s;
        logic xt_m, xt_s, xt_p;
        logic pwr_m, pwr_s;
        logic lock_m, lock_s;
        logic [7:0] power_configuration;
        logic [7:0] device_configuration;
        logic [7:0] control_calibration;
        logic [7:0] crystal_divisor;
        logic [7:0] sleep_interval_high;
        logic [7:0] sleep_interval_low;
        logic [7:0] host_wake_delay;
        logic [7:0] rf_settle_high;
        logic [7:0] rf_settle_low;
        logic [7:0] gain_hold_time;
        logic poll_cal_done;
        logic item_a;
        logic [15:0] shift;
        logic [4:0] bit_cnt;
        logic rd_next, rd_act;
        logic [3:0] rd_addr;
        logic [7:0] rd_sh;
        logic mreset;
        logic [7:0] poll_cnt;
        logic [8:0] fsk_cnt;
        logic [31:0] dwell_cnt;
        logic lna_high;
        logic [8:0] alive_cnt;
        drx_state_t discontinuous_receive;
        logic [23:0] drx_cnt;
        logic host_ack;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic ref_tick;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, xt_rise;
    logic [15:0] shift_new;
    logic [4:0] cnt_new;
    logic [7:0] status;
    logic [31:0] dwell_target;
    logic [8:0] fsk_target;
    logic drx_on, alive;

    assign sclk_rise = s_q.sclk_s & ~s_q.sclk_p;
    assign sclk_fall = ~s_q.sclk_s & s_q.sclk_p;
    assign cs_fall = ~s_q.cs_s & s_q.cs_p;
    assign cs_rise = s_q.cs_s & ~s_q.cs_p;
    assign xt_rise = s_q.xt_s & ~s_q.xt_p;
    assign drx_on = s_q.device_configuration[rx_cfg_pkg::CFG_DRX_BIT];
    assign alive = s_q.alive_cnt < 9'(rx_cfg_pkg::ALIVE_TIMEOUT_CYC);
    assign dwell_target = 32'((33'h1 << s_q.gain_hold_time[4:0]) - 33'h1);
    assign fsk_target =
        s_q.device_configuration[rx_cfg_pkg::CFG_ACCURACY_BIT] ?
        9'(rx_cfg_pkg::FSK_CAL_FULL_TICKS) :
        9'(rx_cfg_pkg::FSK_CAL_SHORT_TICKS);

    // ==================================================
    // Status and read data
    always_comb begin
        status = 8'h00;
        status[rx_cfg_pkg::STS_LOCK_BIT] = s_q.lock_s;
        status[rx_cfg_pkg::STS_AGC_BIT] = ~s_q.lna_high;
        status[rx_cfg_pkg::STS_ALIVE_BIT] = alive;
        status[rx_cfg_pkg::STS_POLL_DONE_BIT] = s_q.poll_cal_done;
        status[rx_cfg_pkg::STS_FSK_DONE_BIT] = s_q.item_a;
    end

    function automatic logic [7:0] read_mux(input state_t st,
                                            input logic [3:0] a,
                                            input logic [7:0] sts);
        case (a)
            rx_cfg_pkg::ADDR_POWER: read_mux = st.power_configuration;
            rx_cfg_pkg::ADDR_CONFIG: read_mux = st.device_configuration;
            rx_cfg_pkg::ADDR_CONTROL: read_mux = st.control_calibration;
            rx_cfg_pkg::ADDR_XTAL_DIV: read_mux = st.crystal_divisor;
            rx_cfg_pkg::ADDR_SLEEP_HI: read_mux = st.sleep_interval_high;
            rx_cfg_pkg::ADDR_SLEEP_LO: read_mux = st.sleep_interval_low;
            rx_cfg_pkg::ADDR_WAKE_DLY: read_mux = st.host_wake_delay;
            rx_cfg_pkg::ADDR_SETTLE_HI: read_mux = st.rf_settle_high;
            rx_cfg_pkg::ADDR_SETTLE_LO: read_mux = st.rf_settle_low;
            rx_cfg_pkg::ADDR_STATUS: read_mux = sts;
            rx_cfg_pkg::ADDR_GAIN_HOLD: read_mux = st.gain_hold_time;
            default: read_mux = 8'h00;
        endcase
    endfunction

    // ==================================================
    // Reference divider, gated by the mixer enable bit
    ref_divider u_ref_divider (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .xtal_rise(xt_rise),
        .enable(s_q.power_configuration[rx_cfg_pkg::PWR_MIXER_EN_BIT]),
        .divisor(s_q.crystal_divisor),
        .ref_tick(ref_tick)
    );

    assign shift_new = {s_q.shift[14:0], s_q.dio_s};
    assign cnt_new = s_q.bit_cnt + 5'h01;

    // ==================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.sclk_m = SCLK;
        s_d.sclk_s = s_q.sclk_m;
        s_d.sclk_p = s_q.sclk_s;
        s_d.cs_m = CHIP_SEL_N;
        s_d.cs_s = s_q.cs_m;
        s_d.cs_p = s_q.cs_s;
        s_d.dio_m = BIDIR_SERIAL_LINE_IN;
        s_d.dio_s = s_q.dio_m;
        s_d.xt_m = XTAL_CLK;
        s_d.xt_s = s_q.xt_m;
        s_d.xt_p = s_q.xt_s;
        s_d.pwr_m = POWER_BELOW_THRESH;
        s_d.pwr_s = s_q.pwr_m;
        s_d.lock_m = PLL_LOCKED;
        s_d.lock_s = s_q.lock_m;

        // Serial frame capture
        if (cs_fall) begin
            s_d.bit_cnt = 5'h00;
            s_d.mreset = 1'b0;
            if (s_q.rd_next) begin
                s_d.rd_act = 1'b1;
                s_d.rd_next = 1'b0;
                s_d.rd_sh = read_mux(s_q, s_q.rd_addr, status);
            end
        end else if (cs_rise) begin
            s_d.rd_act = 1'b0;
        end else if (!s_q.cs_s && s_q.rd_act) begin
            if (sclk_fall) begin
                s_d.rd_sh = {s_q.rd_sh[6:0], 1'b0};
            end
        end else if (!s_q.cs_s && sclk_rise &&
                     s_q.bit_cnt < 5'(rx_cfg_pkg::FRAME_BITS)) begin
            s_d.shift = shift_new;
            s_d.bit_cnt = cnt_new;
            if (cnt_new == 5'(rx_cfg_pkg::FRAME_HDR_BITS)) begin
                case (shift_new[7:4])
                    rx_cfg_pkg::CMD_READ: begin
                        s_d.rd_next = 1'b1;
                        s_d.rd_addr = shift_new[3:0];
                    end
                    rx_cfg_pkg::CMD_MRESET: s_d.mreset = 1'b1;
                    default: s_d.mreset = s_q.mreset;
                endcase
            end
            if (cnt_new == 5'(rx_cfg_pkg::FRAME_BITS) &&
                shift_new[15:12] == rx_cfg_pkg::CMD_WRITE) begin
                case (shift_new[11:8])
                    rx_cfg_pkg::ADDR_POWER:
                        s_d.power_configuration = shift_new[7:0];
                    rx_cfg_pkg::ADDR_CONFIG:
                        s_d.device_configuration = shift_new[7:0];
                    rx_cfg_pkg::ADDR_CONTROL: begin
                        s_d.control_calibration = shift_new[7:0] |
                            (s_q.control_calibration & 8'h03);
                        if (shift_new[rx_cfg_pkg::CTL_POLL_START_BIT]) begin
                            s_d.poll_cal_done = 1'b0;
                            s_d.poll_cnt = 8'h00;
                        end
                        if (shift_new[rx_cfg_pkg::CTL_FSK_START_BIT]) begin
                            s_d.item_a = 1'b0;
                            s_d.fsk_cnt = 9'h000;
                        end
                    end
                    rx_cfg_pkg::ADDR_XTAL_DIV:
                        s_d.crystal_divisor = shift_new[7:0];
                    rx_cfg_pkg::ADDR_SLEEP_HI:
                        s_d.sleep_interval_high = shift_new[7:0];
                    rx_cfg_pkg::ADDR_SLEEP_LO:
                        s_d.sleep_interval_low = shift_new[7:0];
                    rx_cfg_pkg::ADDR_WAKE_DLY:
                        s_d.host_wake_delay = shift_new[7:0];
                    rx_cfg_pkg::ADDR_SETTLE_HI:
                        s_d.rf_settle_high = shift_new[7:0];
                    rx_cfg_pkg::ADDR_SETTLE_LO:
                        s_d.rf_settle_low = shift_new[7:0];
                    rx_cfg_pkg::ADDR_GAIN_HOLD:
                        s_d.gain_hold_time = shift_new[7:0];
                    default: s_d.shift = shift_new;
                endcase
            end
        end

        // Calibration runs, timed by the reference
        if (s_q.control_calibration[rx_cfg_pkg::CTL_POLL_START_BIT] &&
            ref_tick) begin
            if (s_q.poll_cnt == 8'(rx_cfg_pkg::POLL_CAL_TICKS - 1)) begin
                s_d.control_calibration[rx_cfg_pkg::CTL_POLL_START_BIT] =
                    1'b0;
                s_d.poll_cal_done = 1'b1;
                s_d.poll_cnt = 8'h00;
            end else begin
                s_d.poll_cnt = s_q.poll_cnt + 8'h01;
            end
        end
        if (s_q.control_calibration[rx_cfg_pkg::CTL_FSK_START_BIT] &&
            ref_tick) begin
            if (s_q.fsk_cnt >= fsk_target - 9'h001) begin
                s_d.control_calibration[rx_cfg_pkg::CTL_FSK_START_BIT] =
                    1'b0;
                s_d.item_a = 1'b1;
                s_d.fsk_cnt = 9'h000;
            end else begin
                s_d.fsk_cnt = s_q.fsk_cnt + 9'h001;
            end
        end

        // Gain control with dwell in crystal periods
        if (!s_q.power_configuration[rx_cfg_pkg::PWR_AGC_EN_BIT]) begin
            s_d.lna_high = 1'b1;
            s_d.dwell_cnt = 32'h0000_0000;
        end else if (s_q.control_calibration[rx_cfg_pkg::CTL_AGC_LOCK_BIT]) begin
            s_d.dwell_cnt = 32'h0000_0000;
        end else if (!s_q.pwr_s) begin
            s_d.lna_high = 1'b0;
            s_d.dwell_cnt = 32'h0000_0000;
        end else if (!s_q.lna_high && xt_rise) begin
            if (s_q.dwell_cnt >= dwell_target) begin
                s_d.lna_high = 1'b1;
            end else begin
                s_d.dwell_cnt = s_q.dwell_cnt + 32'h0000_0001;
            end
        end

        // Crystal activity
        if (xt_rise) begin
            s_d.alive_cnt = 9'h000;
        end else if (alive) begin
            s_d.alive_cnt = s_q.alive_cnt + 9'h001;
        end

        // Discontinuous receive wake sequence
        if (!drx_on || !s_q.cs_s) begin
            s_d.discontinuous_receive = DRX_IDLE;
        end else begin
            case (s_q.discontinuous_receive)
                DRX_IDLE: begin
                    if (s_q.dio_s) begin
                        s_d.discontinuous_receive = DRX_OFF;
                        s_d.drx_cnt = 24'({s_q.sleep_interval_high,
                            s_q.sleep_interval_low} << (rx_cfg_pkg::
                            SLEEP_BASE_SHIFT * s_q.device_configuration[
                            rx_cfg_pkg::CFG_PRESCALE_LSB +: 2]));
                    end
                end
                DRX_OFF: begin
                    if (ref_tick) begin
                        if (s_q.drx_cnt == 24'h00_0000) begin
                            s_d.discontinuous_receive = DRX_CPU;
                            s_d.drx_cnt = 24'(s_q.host_wake_delay *
                                rx_cfg_pkg::WAKE_STEP_TICKS);
                        end else begin
                            s_d.drx_cnt = s_q.drx_cnt - 24'h00_0001;
                        end
                    end
                end
                DRX_CPU: begin
                    if (ref_tick) begin
                        if (s_q.drx_cnt == 24'h00_0000) begin
                            s_d.discontinuous_receive = DRX_RF;
                            s_d.host_ack = 1'b0;
                            s_d.drx_cnt = 24'({s_q.rf_settle_high,
                                s_q.rf_settle_low} *
                                rx_cfg_pkg::SETTLE_BASE_TICKS);
                            s_d.control_calibration[
                                rx_cfg_pkg::CTL_POLL_START_BIT] = 1'b1;
                            s_d.poll_cnt = 8'h00;
                            s_d.poll_cal_done = 1'b0;
                            if (s_q.power_configuration[
                                rx_cfg_pkg::PWR_FSKBB_EN_BIT]) begin
                                s_d.control_calibration[
                                    rx_cfg_pkg::CTL_FSK_START_BIT] = 1'b1;
                                s_d.fsk_cnt = 9'h000;
                                s_d.item_a = 1'b0;
                            end
                        end else begin
                            s_d.drx_cnt = s_q.drx_cnt - 24'h00_0001;
                        end
                    end
                end
                DRX_RF: begin
                    if (!s_q.dio_s) begin
                        s_d.host_ack = 1'b1;
                    end
                    if (ref_tick) begin
                        if (s_q.drx_cnt == 24'h00_0000) begin
                            s_d.discontinuous_receive = (s_q.host_ack || !s_q.dio_s) ?
                                DRX_RECV : DRX_IDLE;
                        end else begin
                            s_d.drx_cnt = s_q.drx_cnt - 24'h00_0001;
                        end
                    end
                end
                DRX_RECV: begin
                    if (s_q.dio_s) begin
                        s_d.discontinuous_receive = DRX_IDLE;
                    end
                end
                default: s_d.discontinuous_receive = DRX_IDLE;
            endcase
        end

        // Master reset returns registers to power-up values
        if (s_q.mreset) begin
            s_d.power_configuration = rx_cfg_pkg::RST_ZERO;
            s_d.device_configuration = rx_cfg_pkg::RST_CONFIG;
            s_d.control_calibration = rx_cfg_pkg::RST_ZERO;
            s_d.crystal_divisor = rx_cfg_pkg::RST_ZERO;
            s_d.sleep_interval_high = rx_cfg_pkg::RST_ZERO;
            s_d.sleep_interval_low = rx_cfg_pkg::RST_ZERO;
            s_d.host_wake_delay = rx_cfg_pkg::RST_ZERO;
            s_d.rf_settle_high = rx_cfg_pkg::RST_ZERO;
            s_d.rf_settle_low = rx_cfg_pkg::RST_ZERO;
            s_d.gain_hold_time = rx_cfg_pkg::RST_GAIN_HOLD;
            s_d.poll_cal_done = 1'b0;
            s_d.item_a = 1'b0;
            s_d.discontinuous_receive = DRX_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
            s_q.cs_m <= 1'b1;
            s_q.cs_s <= 1'b1;
            s_q.cs_p <= 1'b1;
            s_q.device_configuration <= rx_cfg_pkg::RST_CONFIG;
            s_q.gain_hold_time <= rx_cfg_pkg::RST_GAIN_HOLD;
            s_q.alive_cnt <= 9'(rx_cfg_pkg::ALIVE_TIMEOUT_CYC);
            s_q.discontinuous_receive <= DRX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==================================================
    // Outputs
    assign BIDIR_SERIAL_LINE_OUT = s_q.rd_act ? s_q.rd_sh[7] : 1'b0;
    assign BIDIR_SERIAL_LINE_OE_N = ~(s_q.rd_act || s_q.discontinuous_receive == DRX_CPU);
    assign POWER_CONFIG = s_q.power_configuration;
    assign DEVICE_CONFIG = s_q.device_configuration;
    assign XTAL_DIVISOR = s_q.crystal_divisor;
    assign REF_TICK = ref_tick;
    assign LNA_HIGH_GAIN = s_q.lna_high;
    assign RX_MODULES_ON = !drx_on || s_q.discontinuous_receive == DRX_RF ||
        s_q.discontinuous_receive == DRX_RECV;
    assign PEAK_DET_HOLD = s_q.discontinuous_receive == DRX_RF;
    assign DATA_OUT_EN = !drx_on || s_q.discontinuous_receive == DRX_RECV;
    assign ASK_TRACK_EN = s_q.control_calibration[2];
    assign FSK_TRACK_EN = s_q.control_calibration[3];

endmodule // rx_config_calibration_regs

`default_nettype wire

// file: rtl/rx_cfg_pkg.sv
package rx_cfg_pkg;

    // ==================================================
    // Commands and register addresses
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE = 4'h1;
    localparam logic [3:0] CMD_READ = 4'h2;
    localparam logic [3:0] CMD_MRESET = 4'h3;

    localparam logic [3:0] ADDR_POWER = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_XTAL_DIV = 4'h3;
    localparam logic [3:0] ADDR_SLEEP_HI = 4'h4;
    localparam logic [3:0] ADDR_SLEEP_LO = 4'h5;
    localparam logic [3:0] ADDR_WAKE_DLY = 4'h6;
    localparam logic [3:0] ADDR_SETTLE_HI = 4'h7;
    localparam logic [3:0] ADDR_SETTLE_LO = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h9;
    localparam logic [3:0] ADDR_GAIN_HOLD = 4'hA;

    // ==================================================
    // Field positions
    localparam int PWR_AGC_EN_BIT = 6;
    localparam int PWR_MIXER_EN_BIT = 5;
    localparam int PWR_FSKBB_EN_BIT = 4;
    localparam int CFG_ACCURACY_BIT = 5;
    localparam int CFG_PRESCALE_LSB = 1;
    localparam int CFG_DRX_BIT = 0;
    localparam int CTL_AGC_LOCK_BIT = 6;
    localparam int CTL_POLL_START_BIT = 1;
    localparam int CTL_FSK_START_BIT = 0;
    localparam int STS_LOCK_BIT = 7;
    localparam int STS_AGC_BIT = 6;
    localparam int STS_ALIVE_BIT = 5;
    localparam int STS_POLL_DONE_BIT = 1;
    localparam int STS_FSK_DONE_BIT = 0;
    localparam int FRAME_HDR_BITS = 8;
    localparam int FRAME_BITS = 16;

    // ==================================================
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h40;
    localparam logic [7:0] RST_GAIN_HOLD = 8'h0D;

    // ==================================================
    // Timing
    localparam int SYS_CLK_HZ = 250_000_000;
    localparam int REF_HZ = 100_000;
    localparam int REF_PERIOD_US = 1_000_000 / REF_HZ;
    localparam int WAKE_STEP_US = 120;
    localparam int WAKE_STEP_TICKS = WAKE_STEP_US / REF_PERIOD_US;
    localparam int SLEEP_BASE_SHIFT = 2;
    localparam int SETTLE_BASE_TICKS = 1;
    localparam int POLL_CAL_TICKS = 64;
    localparam int FSK_CAL_FULL_TICKS = 256;
    localparam int FSK_CAL_SHORT_TICKS = 32;
    localparam int ALIVE_TIMEOUT_NS = 1000;
    localparam int ALIVE_TIMEOUT_CYC =
        ALIVE_TIMEOUT_NS / (1_000_000_000 / SYS_CLK_HZ);

endpackage

// file: rtl/ref_divider.sv
`timescale 1ns/1ps
`default_nettype none

module ref_divider (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic xtal_rise,
    input wire logic enable,
    input wire logic [7:0] divisor,
    output logic ref_tick
);

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    // ==================================================
    // Crystal edges counted down to the reference
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!enable || divisor == 8'h00) begin
            s_d.cnt = 8'h00;
        end else if (xtal_rise) begin
            if (s_q.cnt >= divisor - 8'h01) begin
                s_d.cnt = 8'h00;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ref_tick = s_q.tick;

endmodule // ref_divider

`default_nettype wire

// file: verification/rx_cfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Port relations
module rx_cfg_chk (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic CHIP_SEL_N,
    input wire logic POWER_BELOW_THRESH,
    input wire logic BIDIR_SERIAL_LINE_OUT,
    input wire logic BIDIR_SERIAL_LINE_OE_N,
    input wire logic [7:0] POWER_CONFIG,
    input wire logic [7:0] DEVICE_CONFIG,
    input wire logic [7:0] XTAL_DIVISOR,
    input wire logic REF_TICK,
    input wire logic LNA_HIGH_GAIN,
    input wire logic RX_MODULES_ON,
    input wire logic PEAK_DET_HOLD,
    input wire logic DATA_OUT_EN
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_quiet;
        (CHIP_SEL_N && !DEVICE_CONFIG[0]) [*8];
    endsequence
    sequence s_cs_idle;
        CHIP_SEL_N [*8];
    endsequence
    property p_tick; REF_TICK && XTAL_DIVISOR > 8'h01 |=> !REF_TICK; endproperty
    property p_idle; s_quiet |-> BIDIR_SERIAL_LINE_OE_N; endproperty
    property p_low;
        s_cs_idle ##0 !BIDIR_SERIAL_LINE_OE_N |-> !BIDIR_SERIAL_LINE_OUT;
    endproperty
    property p_cont;
        !DEVICE_CONFIG[0] [*3] |-> RX_MODULES_ON && DATA_OUT_EN && !PEAK_DET_HOLD;
    endproperty
    property p_hold; PEAK_DET_HOLD |-> RX_MODULES_ON && !DATA_OUT_EN; endproperty
    property p_out; DATA_OUT_EN |-> RX_MODULES_ON; endproperty
    property p_gain;
        $rose(LNA_HIGH_GAIN) && POWER_CONFIG[6] |-> $past(POWER_BELOW_THRESH, 3);
    endproperty
    property p_stable;
        s_quiet |-> $stable(POWER_CONFIG) && $stable(XTAL_DIVISOR);
    endproperty
    a_tick: assert property (p_tick) else $error("tick too wide");
    a_idle: assert property (p_idle) else $error("line driven idle");
    a_low: assert property (p_low) else $error("wake not low");
    a_cont: assert property (p_cont) else $error("cont outputs");
    a_hold: assert property (p_hold) else $error("settle outputs");
    a_out: assert property (p_out) else $error("output unpowered");
    a_gain: assert property (p_gain) else $error("gain rise early");
    a_stable: assert property (p_stable) else $error("reg moved");
endmodule // rx_cfg_chk
bind rx_config_calibration_regs rx_cfg_chk chk (.*);
`default_nettype wire

// file: verification/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Host side of the serial link
module host_link_model (
    input wire logic clk,
    input wire logic line,
    output logic sclk,
    output logic cs_n,
    output logic h_z,
    output logic h_v
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        h_z = 1'b0;
        h_v = 1'b0;
    end
    task automatic frame(input logic [15:0] w, input int n,
                         input logic rd, output logic [7:0] q);
        q = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        h_z <= rd;
        for (int i = 0; i < n; i++) begin
            h_v <= w[15-i];
            sclk <= 1'b0;
            repeat (6) @(posedge clk);
            sclk <= 1'b1;
            q = {q[6:0], line};
            repeat (6) @(posedge clk);
        end
        sclk <= 1'b0;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        h_z <= 1'b0;
        h_v <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
endmodule // host_link_model
`default_nettype wire

// file: verification/rx_config_calibration_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module rx_config_calibration_regs_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic xtal = 1'b0;
    logic below = 1'b0;
    logic pll = 1'b1;
    logic sclk, cs_n, h_z, h_v, d_out, d_oe_n, line, lna, tick;
    logic mods, hold, dout, ask, fsk;
    logic [7:0] pwr, cfg, div;
    int err_count = 0;
    int comparisons = 0;
    assign line = !d_oe_n ? d_out : (!h_z ? h_v : 1'b1);
    host_link_model host (.clk(clk), .line(line), .sclk(sclk), .cs_n(cs_n),
        .h_z(h_z), .h_v(h_v));
    rx_config_calibration_regs dut (.SYS_CLK(clk), .RESET_N(rst_n),
        .SCLK(sclk), .CHIP_SEL_N(cs_n), .BIDIR_SERIAL_LINE_IN(line),
        .BIDIR_SERIAL_LINE_OUT(d_out), .BIDIR_SERIAL_LINE_OE_N(d_oe_n),
        .XTAL_CLK(xtal), .POWER_BELOW_THRESH(below), .PLL_LOCKED(pll),
        .POWER_CONFIG(pwr), .DEVICE_CONFIG(cfg), .XTAL_DIVISOR(div),
        .REF_TICK(tick), .LNA_HIGH_GAIN(lna), .RX_MODULES_ON(mods),
        .PEAK_DET_HOLD(hold), .DATA_OUT_EN(dout), .ASK_TRACK_EN(ask),
        .FSK_TRACK_EN(fsk));
    // ==================================================
    // Helpers
    initial forever #2 clk = ~clk;
    always begin
        repeat (5) @(posedge clk);
        xtal <= ~xtal;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.frame({rx_cfg_pkg::CMD_WRITE, a, d}, 16, 1'b0, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        host.frame({rx_cfg_pkg::CMD_READ, a, 8'h00}, 16, 1'b0, q);
        host.frame(16'h0000, 8, 1'b1, q);
    endtask
    function automatic logic [7:0] pat(input logic [3:0] a);
        return 8'h0C ^ {3'b000, a, 1'b0};
    endfunction
    task automatic results;
        $display("Comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==================================================
    // Scenarios
    task automatic t_regs;
        logic [7:0] q;
        for (int a = 0; a < 11; a++) begin
            if (a == 9) continue;
            rd(4'(a), q);
            check(q, a == 1 ? rx_cfg_pkg::RST_CONFIG : a == 10 ?
                rx_cfg_pkg::RST_GAIN_HOLD : rx_cfg_pkg::RST_ZERO);
            wr(4'(a), pat(4'(a)));
            rd(4'(a), q);
            check(q, pat(4'(a)));
        end
        check({pwr[3:0], cfg[3:0]}, 8'({pat(0), 4'h0} | pat(1) & 8'h0F));
        check({fsk, ask}, 8'h02);
    endtask
    task automatic t_refuse;
        logic [7:0] q;
        wr(4'h9, 8'hFF);
        rd(4'h9, q);
        check(q & 8'h83, 8'h80);
        for (int c = 0; c < 16; c++)
            if (c == 0 || c > 3) host.frame({4'(c), 12'h3FF}, 16, 1'b0, q);
        host.frame(16'h13FF, 12, 1'b0, q);
        check(div, pat(4'h3));
    endtask
    task automatic t_cal;
        logic [7:0] q;
        int n;
        wr(4'h0, 8'h20);
        wr(4'h3, 8'h02);
        for (n = 0; n < 100 && tick !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 100 && tick !== 1'b1; n++) @(posedge clk);
        check(8'(n), 8'd20);
        wr(4'h2, 8'h02);
        rd(4'h2, q);
        check(q & 8'h03, 8'h02);
        rd(4'h9, q);
        check(q & 8'h03, 8'h00);
        repeat (1300) @(posedge clk);
        rd(4'h2, q);
        check(q & 8'h03, 8'h00);
        rd(4'h9, q);
        check(q & 8'h02, 8'h02);
        for (int acc = 0; acc < 2; acc++) begin
            wr(4'h1, acc == 1 ? 8'h20 : 8'h00);
            wr(4'h2, 8'h01);
            repeat (700) @(posedge clk);
            rd(4'h9, q);
            check(q & 8'h01, 8'(1 - acc));
            repeat (5200) @(posedge clk);
            rd(4'h2, q);
            check(q & 8'h01, 8'h00);
            rd(4'h9, q);
            check(q & 8'h01, 8'h01);
        end
    endtask
    task automatic t_mreset;
        logic [7:0] q;
        wr(4'hA, 8'h05);
        host.frame({rx_cfg_pkg::CMD_MRESET, 12'h000}, 8, 1'b0, q);
        check(cfg, rx_cfg_pkg::RST_CONFIG);
        check(div, rx_cfg_pkg::RST_ZERO);
        rd(4'hA, q);
        check(q, rx_cfg_pkg::RST_GAIN_HOLD);
    endtask
    task automatic t_agc;
        wr(4'hA, 8'h02);
        wr(4'h0, 8'h60);
        repeat (20) @(posedge clk);
        check({7'h00, lna}, 8'h00);
        below <= 1'b1;
        repeat (20) @(posedge clk);
        check({7'h00, lna}, 8'h00);
        repeat (80) @(posedge clk);
        check({7'h00, lna}, 8'h01);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_refuse();
        t_cal();
        t_mreset();
        t_agc();
        results();
    end
    initial begin
        #200000;
        err_count++;
        results();
    end
endmodule // rx_config_calibration_regs_test
`default_nettype wire
